// [inc/cc_pkg.sv]
// Constants, register map and carrier types of the capture/compare unit.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package cc_pkg;
    localparam int NCH = 16;
    localparam int TW  = 16;
    localparam int NEV = NCH + 2;
    localparam int PW  = 8;

    // Byte offsets
    localparam logic [7:0] OFS_TCTL0  = 8'h00;
    localparam logic [7:0] OFS_TCTL1  = 8'h04;
    localparam logic [7:0] OFS_RELOAD0 = 8'h08;
    localparam logic [7:0] OFS_RELOAD1 = 8'h0C;
    localparam logic [7:0] OFS_COUNT0 = 8'h10;
    localparam logic [7:0] OFS_COUNT1 = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CLEAR  = 8'h1C;
    localparam logic [7:0] OFS_ENABLE = 8'h20;
    localparam logic [7:0] OFS_GCTL   = 8'h24;
    localparam logic [1:0] PAGE_CHMODE = 2'h1;
    localparam logic [1:0] PAGE_CHVAL  = 2'h2;

    localparam logic [TW-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [2:0]    STAG_LAST = 3'h7;

    // Timer clock sources
    localparam logic [1:0] SRC_PRESC    = 2'h0;
    localparam logic [1:0] SRC_UPSTREAM = 2'h1;
    localparam logic [1:0] SRC_CIN      = 2'h2;

    typedef enum logic [2:0] {
        CH_OFF     = 3'b000,
        CH_CAPTURE = 3'b001,
        CH_CMP0    = 3'b010,
        CH_CMP1    = 3'b011,
        CH_CMP2    = 3'b100,
        CH_CMP3    = 3'b101,
        CH_DOUBLE  = 3'b110
    } ch_mode_t;

    // Channel mode register, bits 6:0
    typedef struct packed {
        logic       single;
        logic       tsel;
        logic [1:0] edge_sel;
        ch_mode_t   mode;
    } ch_cfg_t;

    // Timer control register, bits 5:0
    typedef struct packed {
        logic [2:0] psel;
        logic [1:0] src;
        logic       run;
    } tmr_cfg_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avs_req_t;
endpackage

// [core/capture_compare_unit.sv]
// Sixteen-channel capture/compare unit with two reloadable time bases.
// Assumes pins and count inputs synchronous to clk_i, an Avalon-MM
// master and a one-cycle overflow pulse from the upstream timer six.
`timescale 1ns/1ps
module capture_compare_unit
    import cc_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    // Avalon-MM slave
    input  wire avs_req_t            avs_i,
    output logic [31:0]              avs_readdata_o,
    output logic                     avs_waitrequest_o,
    // Timer sources
    input  wire logic                upstream_timer_six_evt_i,
    input  wire logic [1:0]          count_in_i,
    // Channel pins
    input  wire logic [NCH-1:0]      pin_i,
    output logic [NCH-1:0]           pin_o,
    output logic [NCH-1:0]           pin_oe_o,
    // Interrupt
    output logic                     irq_o
);

    typedef struct packed {
        logic [PW-1:0]             pre;
        logic [1:0][TW-1:0]        cnt;
        logic [1:0][TW-1:0]        rel;
        tmr_cfg_t [1:0]            tcfg;
        logic [1:0]                tick;
        logic [1:0]                fresh;
        logic [1:0]                cin_prev;
        logic                      stag;
        logic [NCH-1:0][TW-1:0]    val;
        ch_cfg_t [NCH-1:0]         cfg;
        logic [NCH-1:0]            done;
        logic [NCH-1:0]            once;
        logic [NCH-1:0]            pin_prev;
        logic [NCH-1:0]            pin;
        logic [NCH-1:0]            oe;
        logic [NEV-1:0]            status;
        logic [NEV-1:0]            enable;
        logic                      irq;
        logic                      waitreq;
        logic [31:0]               rdata;
    } state_t;

    state_t            q;
    state_t            d;
    logic [NCH-1:0]    chev;
    logic [1:0]        tk;
    logic [1:0]        ovf;
    logic [NEV-1:0]    clr;
    logic [PW-1:0]     pmask;
    logic [31:0]       rd;
    logic [7:0]        a;
    logic [3:0]        c;
    logic              wr;
    logic              t;
    logic              ev;
    logic              hit;
    logic              rise;
    logic              fall;
    logic              dbl;
    logic [TW-1:0]     cur;
    logic [TW-1:0]     cap_cur;

    function automatic logic [TW-1:0] merge(input logic [TW-1:0] o,
                                            input logic [31:0]   w,
                                            input logic [3:0]    be);
        logic [TW-1:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return (o & ~m) | (w[TW-1:0] & m);
    endfunction

    always_comb begin
        d     = q;
        chev  = '0;
        tk    = '0;
        ovf   = '0;
        clr   = '0;
        pmask = '0;
        rd    = '0;
        t     = 1'b0;
        ev    = 1'b0;
        hit   = 1'b0;
        rise  = 1'b0;
        fall  = 1'b0;
        dbl   = 1'b0;
        cur   = '0;
        a     = avs_i.address;
        c     = a[5:2];
        wr    = avs_i.write & ~q.waitreq;

        // Bus: one wait cycle, then answer; write lands on the answer edge
        d.waitreq = ~((avs_i.read | avs_i.write) & q.waitreq);
        case (a)
            OFS_TCTL0:   rd = 32'(q.tcfg[0]);
            OFS_TCTL1:   rd = 32'(q.tcfg[1]);
            OFS_RELOAD0: rd = 32'(q.rel[0]);
            OFS_RELOAD1: rd = 32'(q.rel[1]);
            OFS_COUNT0:  rd = 32'(q.cnt[0]);
            OFS_COUNT1:  rd = 32'(q.cnt[1]);
            OFS_STATUS:  rd = 32'(q.status);
            OFS_ENABLE:  rd = 32'(q.enable);
            OFS_GCTL:    rd = 32'(q.stag);
            default: begin
                if (a[7:6] == PAGE_CHMODE) begin
                    rd = 32'(q.cfg[c]);
                end else if (a[7:6] == PAGE_CHVAL) begin
                    rd = 32'(q.val[c]);
                end
            end
        endcase
        if ((avs_i.read | avs_i.write) & q.waitreq) begin
            d.rdata = rd;
        end
        if (wr) begin
            case (a)
                OFS_TCTL0: begin
                    if (avs_i.byteenable[0]) begin
                        d.tcfg[0] = tmr_cfg_t'(avs_i.writedata[5:0]);
                    end
                end
                OFS_TCTL1: begin
                    if (avs_i.byteenable[0]) begin
                        d.tcfg[1] = tmr_cfg_t'(avs_i.writedata[5:0]);
                    end
                end
                OFS_RELOAD0: d.rel[0] = merge(q.rel[0], avs_i.writedata,
                                              avs_i.byteenable);
                OFS_RELOAD1: d.rel[1] = merge(q.rel[1], avs_i.writedata,
                                              avs_i.byteenable);
                OFS_CLEAR:   clr = avs_i.writedata[NEV-1:0];
                OFS_ENABLE:  d.enable = avs_i.writedata[NEV-1:0];
                OFS_GCTL:    d.stag = avs_i.writedata[0];
                default: begin
                    if (a[7:6] == PAGE_CHMODE) begin
                        // Rewriting the mode re-arms single event and once
                        d.cfg[c]  = ch_cfg_t'(avs_i.writedata[6:0]);
                        d.done[c] = 1'b0;
                        d.once[c] = 1'b0;
                    end else if (a[7:6] == PAGE_CHVAL) begin
                        d.val[c] = merge(q.val[c], avs_i.writedata,
                                         avs_i.byteenable);
                    end
                end
            endcase
        end

        // Time bases
        d.pre = q.pre + 1'b1;
        for (int i = 0; i < 2; i++) begin
            pmask = ~({PW{1'b1}} << q.tcfg[i].psel);
            case (q.tcfg[i].src)
                SRC_PRESC: tk[i] = ((q.pre & pmask) == pmask) &
                                   (~q.stag | (q.pre[2:0] == STAG_LAST));
                SRC_UPSTREAM: tk[i] = upstream_timer_six_evt_i;
                SRC_CIN:   tk[i] = count_in_i[i] & ~q.cin_prev[i];
                default:   tk[i] = 1'b0;
            endcase
            tk[i]  = tk[i] & q.tcfg[i].run;
            ovf[i] = tk[i] & (q.cnt[i] == CNT_MAX);
            if (ovf[i]) begin
                d.cnt[i] = q.rel[i];
            end else if (tk[i]) begin
                d.cnt[i] = q.cnt[i] + 1'b1;
            end
            d.tick[i]     = tk[i];
            d.fresh[i]    = tk[i] |
                            (q.fresh[i] & (q.pre[2:0] != STAG_LAST));
            d.cin_prev[i] = count_in_i[i];
        end

        // Channels
        for (int i = 0; i < NCH; i++) begin
            t   = q.cfg[i].tsel;
            cur = q.cnt[t];
            // Staggered: each channel is looked at once per 8-clock slot
            ev  = q.stag ? (q.fresh[t] & (q.pre[2:0] == 3'(i % 8)))
                         : q.tick[t];
            hit = ev & (cur == q.val[i]) &
                  ~(q.cfg[i].single & q.done[i]);
            rise = pin_i[i] & ~q.pin_prev[i];
            fall = ~pin_i[i] & q.pin_prev[i];
            if (ovf[t]) begin
                d.once[i] = 1'b0;
            end
            case (q.cfg[i].mode)
                CH_CAPTURE: begin
                    if ((rise & q.cfg[i].edge_sel[0]) |
                        (fall & q.cfg[i].edge_sel[1])) begin
                        d.val[i] = cur;
                        chev[i]  = 1'b1;
                    end
                end
                CH_CMP0: chev[i] = hit;
                CH_CMP1: begin
                    if (hit) begin
                        chev[i]  = 1'b1;
                        d.pin[i] = ~d.pin[i];
                    end
                end
                CH_CMP2: begin
                    if (hit & ~q.once[i]) begin
                        chev[i]   = 1'b1;
                        d.once[i] = 1'b1;
                    end
                end
                CH_CMP3: begin
                    if (ovf[t]) begin
                        d.pin[i] = 1'b0;
                    end
                    // A match on the overflow cycle still sets the pin
                    if (hit & ~q.once[i]) begin
                        chev[i]   = 1'b1;
                        d.once[i] = 1'b1;
                        d.pin[i]  = 1'b1;
                    end
                end
                CH_DOUBLE: begin
                    if (hit) begin
                        chev[i] = 1'b1;
                        // Both partners matching together cancel out
                        d.pin[i % 8] = ~d.pin[i % 8];
                    end
                end
                default: ;
            endcase
            if (chev[i] & q.cfg[i].single) begin
                d.done[i] = 1'b1;
            end
            d.pin_prev[i] = pin_i[i];
        end

        for (int i = 0; i < NCH; i++) begin
            dbl = (q.cfg[i % 8].mode == CH_DOUBLE) |
                  (q.cfg[(i % 8) + 8].mode == CH_DOUBLE);
            d.oe[i] = (q.cfg[i].mode == CH_CMP1) |
                      (q.cfg[i].mode == CH_CMP3) |
                      ((i < 8) & dbl);
        end

        // Sticky events: a new event wins over a same-cycle clear
        d.status = (q.status & ~clr) | {ovf, chev};
        d.irq    = |(d.status & d.enable);
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q         <= '0;
            q.waitreq <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_o    = q.rdata;
    assign avs_waitrequest_o = q.waitreq;
    assign pin_o             = q.pin;
    assign pin_oe_o          = q.oe;
    assign irq_o             = q.irq;
    assign cap_cur           = q.cnt[q.cfg[1].tsel];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // One representative channel per mode is watched, except the double mode, which has no assertion
    AST_CAP_LOAD: assert property (
        (q.cfg[1].mode == CH_CAPTURE) && q.cfg[1].edge_sel[0] &&
        pin_i[1] && !q.pin_prev[1] |=> q.val[1] == $past(cap_cur))
        else $error("capture did not load timer count");
    AST_CAP_IRQ: assert property (
        (q.cfg[1].mode == CH_CAPTURE) && q.cfg[1].edge_sel[1] &&
        !pin_i[1] && q.pin_prev[1] |=> q.status[1])
        else $error("capture did not raise request");
    AST_CAP_EDGE: assert property (
        (q.cfg[1].mode == CH_CAPTURE) && (q.cfg[1].edge_sel == 2'b01) &&
        !pin_i[1] && q.pin_prev[1] && !wr |=> $stable(q.val[1]))
        else $error("capture on unselected edge");
    AST_RELOAD: assert property (
        ovf[0] |=> q.cnt[0] == $past(q.rel[0]))
        else $error("timer did not reload on overflow");
    AST_STOP: assert property (
        !q.tcfg[1].run |=> $stable(q.cnt[1]))
        else $error("stopped timer changed");
    AST_TOGGLE: assert property (
        (q.cfg[3].mode == CH_CMP1) && chev[3] &&
        (q.cfg[11].mode != CH_DOUBLE) |=> q.pin[3] != $past(q.pin[3]))
        else $error("mode 1 pin did not toggle");
    AST_CMP3_CLR: assert property (
        (q.cfg[4].mode == CH_CMP3) && ovf[q.cfg[4].tsel] && !chev[4] &&
        (q.cfg[12].mode != CH_DOUBLE) |=> !q.pin[4])
        else $error("mode 3 pin not cleared on overflow");
    AST_ONCE: assert property (
        (q.cfg[5].mode == CH_CMP2) && q.once[5] |-> !chev[5])
        else $error("second mode 2 event in one period");
    AST_SINGLE: assert property (
        (q.cfg[6].mode != CH_CAPTURE) && q.cfg[6].single && q.done[6]
        |-> !chev[6])
        else $error("event after single event completed");
    AST_STAG: assert property (
        q.stag && chev[2] && (q.cfg[2].mode == CH_CMP0)
        |-> q.pre[2:0] == 3'h2)
        else $error("staggered compare outside its slot");

endmodule // capture_compare_unit

// [testbench/pin_partner.sv]
// Pin-side model: outside drivers of the channel pins, the two count
// inputs and the timer six event line. Tasks act just after rising edges.
`timescale 1ns/1ps
module pin_partner
    import cc_pkg::*;
(
    // Clock
    input  wire logic           clk_i,
    // Unit pin drive
    input  wire logic [NCH-1:0] drv_i,
    input  wire logic [NCH-1:0] oe_i,
    // Sources seen by the unit
    output logic [NCH-1:0]      level_o,
    output logic [1:0]          count_o,
    output logic                six_evt_o
);
    logic [NCH-1:0] ext_q;

    // A pin the unit drives shows that drive, otherwise the outside level
    assign level_o = (oe_i & drv_i) | (~oe_i & ext_q);

    initial begin
        ext_q    = '0;
        count_o  = 2'h0;
        six_evt_o = 1'b0;
    end

    // Settles long enough for edge detection and the capture to land
    task automatic set_pin(input int ch, input logic lvl);
        @(posedge clk_i);
        ext_q[ch] <= lvl;
        repeat (3) @(posedge clk_i);
    endtask

    // One-cycle pulses with a gap, so each one is a fresh rising edge
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            @(posedge clk_i);
            if (sel == 2) six_evt_o <= 1'b1;
            else count_o[sel] <= 1'b1;
            @(posedge clk_i);
            six_evt_o <= 1'b0;
            count_o  <= 2'h0;
        end
    endtask
endmodule // pin_partner

// [testbench/tb_sixteen_channel_capture_compare.sv]
// Self-checking bench for the capture/compare unit: Avalon-MM register
// tasks plus the pin partner model. Needs cc_pkg and the unit compiled.
`timescale 1ns/1ps
module tb_sixteen_channel_capture_compare
    import cc_pkg::*;
;
    logic           clk_i    = 1'b0;
    logic           resetn_i = 1'b0;
    avs_req_t       avs_q    = '0;
    logic [31:0]    rdata;
    logic [31:0]    rd;
    logic           wait_o;
    logic [NCH-1:0] pin_i;
    logic [NCH-1:0] pin_o;
    logic [NCH-1:0] pin_oe;
    logic [1:0]     count_in;
    logic           six_evt;
    logic           irq;
    int             num_errors      = 0;
    int             samples_checked = 0;
    int             hi;
    int             n;
    int             chs[7] = '{2, 3, 4, 5, 6, 7, 15};
    logic [6:0]     mds[7] = '{7'h02, 7'h03, 7'h05, 7'h04, 7'h43, 7'h06,
                               7'h06};
    logic [15:0]    vals[7] = '{16'hFFF5, 16'hFFF3, 16'hFFF8, 16'hFFF5,
                                16'hFFF1, 16'hFFF2, 16'hFFFA};

`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    capture_compare_unit DUT (
        .clk_i                    (clk_i),
        .resetn_i                 (resetn_i),
        .avs_i                    (avs_q),
        .avs_readdata_o           (rdata),
        .avs_waitrequest_o        (wait_o),
        .upstream_timer_six_evt_i (six_evt),
        .count_in_i               (count_in),
        .pin_i                    (pin_i),
        .pin_o                    (pin_o),
        .pin_oe_o                 (pin_oe),
        .irq_o                    (irq)
    );

    pin_partner PART (
        .clk_i     (clk_i),
        .drv_i     (pin_o),
        .oe_i      (pin_oe),
        .level_o   (pin_i),
        .count_o   (count_in),
        .six_evt_o (six_evt)
    );

    task automatic test_done();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk_i);
        avs_q.read       <= ~w;
        avs_q.write      <= w;
        avs_q.address    <= a;
        avs_q.writedata  <= d;
        avs_q.byteenable <= 4'hF;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wait_o !== 1'b0 && k < 50);
        if (wait_o !== 1'b0) begin
            num_errors++;
            test_done();
        end
        rd = rdata;
        avs_q.read  <= 1'b0;
        avs_q.write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task automatic rbit(input int b, input logic e);
        repeat (3) @(posedge clk_i);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[b], e)
    endtask

    task automatic hi_cnt(input int ch, input int len);
        hi = 0;
        repeat (len) begin
            @(posedge clk_i);
            if (pin_o[ch] === 1'b1) hi++;
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        rchk(OFS_STATUS, 32'h0);
        rchk(8'h30, 32'h0);
        rchk(OFS_COUNT1, 32'h0);
        wr(OFS_TCTL1, 32'h3);
        PART.pulse(2, 3);
        rchk(OFS_COUNT1, 32'h3);
        wr(OFS_TCTL1, 32'h5);
        PART.pulse(1, 4);
        PART.pulse(0, 2);
        rchk(OFS_COUNT1, 32'h7);
        // Capture on timer one for each edge selection
        wr(OFS_ENABLE, 32'h2);
        for (int e = 1; e < 4; e++) begin
            wr(8'h44, 32'h21 | (32'(e) << 3));
            PART.pulse(1, 1);
            PART.set_pin(1, 1'b1);
            rchk(OFS_STATUS, 32'(e & 1) << 1);
            `CHK(irq, 1'(e & 1))
            if (e[0]) rchk(8'h84, 32'(7 + e));
            wr(OFS_CLEAR, 32'h2);
            PART.set_pin(1, 1'b0);
            rchk(OFS_STATUS, 32'((e >> 1) & 1) << 1);
            wr(OFS_CLEAR, 32'h2);
        end
        // Timer zero runs a full count, then periods of sixteen
        wr(OFS_ENABLE, 32'h0);
        wr(OFS_RELOAD0, 32'hFFF0);
        wr(OFS_TCTL0, 32'h1);
        for (n = 0; n < 25000 && rd[16] !== 1'b1; n++) begin
            bus(1'b0, OFS_STATUS, 32'h0);
        end
        `CHK(rd[16], 1'b1)
        if (rd[16] !== 1'b1) begin
            test_done();
        end
        bus(1'b0, OFS_COUNT0, 32'h0);
        `CHK(rd[15:4], 12'hFFF)
        for (int i = 0; i < 7; i++) begin
            wr(8'(8'h80 + 4 * chs[i]), {16'h0, vals[i]});
            wr(8'(8'h40 + 4 * chs[i]), {25'h0, mds[i]});
        end
        wr(OFS_CLEAR, 32'hFFFFFFFF);
        repeat (20) @(posedge clk_i);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[2], 1'b1)
        `CHK(rd[5], 1'b1)
        `CHK(pin_oe[2], 1'b0)
        `CHK(pin_oe[3], 1'b1)
        hi_cnt(3, 32);
        `CHK(hi, 16)
        // Set lags the match by one clock; the overflow clear lands on the reload edge
        hi_cnt(4, 16);
        `CHK(hi, 7)
        hi_cnt(7, 16);
        `CHK(hi, 8)
        hi_cnt(6, 32);
        `CHK(hi, 32)
        wr(OFS_ENABLE, 32'h4);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b1)
        wr(OFS_ENABLE, 32'h0);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        // Compare on timer one, which only moves on count input edges
        wr(8'hA0, 32'hC);
        wr(8'h60, 32'h22);
        wr(OFS_CLEAR, 32'h100);
        PART.pulse(1, 1);
        rbit(8, 1'b0);
        PART.pulse(1, 1);
        rbit(8, 1'b1);
        // Staggered: timer zero moves once per eight clocks
        wr(OFS_GCTL, 32'h1);
        rchk(OFS_GCTL, 32'h1);
        wr(OFS_CLEAR, 32'h4);
        repeat (130) @(posedge clk_i);
        hi_cnt(3, 256);
        `CHK(hi, 128)
        rbit(2, 1'b1);
        test_done();
    end
endmodule // tb_sixteen_channel_capture_compare
